// ### logic/pss_defines.vh
// Constants shared by the prioritized supply selector logic.
// Assumes a 100 MHz system clock and a classic Wishbone register bus.
`ifndef PSS_DEFINES_VH
`define PSS_DEFINES_VH

// ****************************************
// timing
// ****************************************
`define PSS_CLK_MHZ 100
`define PSS_TICK_US 1000
`define PSS_VALID_MS 256
`define PSS_FAULT_US 8
`define PSS_TICK_CYCLES (`PSS_TICK_US * `PSS_CLK_MHZ)
`define PSS_VALID_TICKS ((`PSS_VALID_MS * 1000) / `PSS_TICK_US)
`define PSS_FAULT_CYCLES (`PSS_FAULT_US * `PSS_CLK_MHZ)

// ****************************************
// register word index, taken from ADR_I[3:2]
// ****************************************
`define PSS_IDX_CTRL 2'h0
`define PSS_IDX_STATUS 2'h1
`define PSS_IDX_EVENT 2'h2

// ****************************************
// control fields and reset values
// ****************************************
`define PSS_CTRL_EN_BIT 0
`define PSS_CTRL_SD_BIT 1
`define PSS_CTRL_EN_RST 1'h1
`define PSS_CTRL_SD_RST 1'h0

// ****************************************
// status fields
// ****************************************
`define PSS_ST_GOOD_LSB 0
`define PSS_ST_GATE_LSB 3
`define PSS_ST_CAS_BIT 6
`define PSS_ST_OFF_LSB 7
`define PSS_ST_FSM_LSB 10

// ****************************************
// event fields
// ****************************************
`define PSS_EV_SWITCH_BIT 0
`define PSS_EV_LOSS_BIT 1

`endif

// ### logic/pss_vtimer.v
// Per-channel validation timer and out-of-window debounce.
// Assumes tick is a one-cycle pulse from the shared timebase.
`timescale 1ns/100ps

module pss_vtimer
#(
   parameter VALID_TICKS = 256,
   parameter FAULT_CYCLES = 800
)
(
   input wire clk,
   input wire rst,
   input wire ce,
   input wire tick,
   input wire clr,
   input wire fault,
   output reg valid,
   output reg fault_long
);

   reg [15:0] cnt;
   reg [15:0] fcnt;
   wire [15:0] full_count;

   // one tick past the limit, so a partial first period never counts
   assign full_count = VALID_TICKS[15:0] + 16'h0001;

   // ****************************************
   // in-window qualification count
   // ****************************************
   // restart on fault
   always @(posedge clk)
   begin
      if (rst)
      begin
         cnt <= 16'h0000;
         valid <= 1'b0;
      end
      else if (ce)
      begin
         if (clr || fault)
         begin
            cnt <= 16'h0000;
            valid <= 1'b0;
         end
         else
         begin
            if (tick && (cnt != full_count))
               cnt <= cnt + 16'h0001;
            valid <= (cnt == full_count);
         end
      end
   end

   // ****************************************
   // out-of-window persistence count
   // ****************************************
   // eight microsecond debounce
   always @(posedge clk)
   begin
      if (rst)
      begin
         fcnt <= 16'h0000;
         fault_long <= 1'b0;
      end
      else if (ce)
      begin
         if (clr || !fault)
         begin
            fcnt <= 16'h0000;
            fault_long <= 1'b0;
         end
         else
         begin
            if (fcnt != FAULT_CYCLES[15:0])
               fcnt <= fcnt + 16'h0001;
            fault_long <= (fcnt >= (FAULT_CYCLES[15:0] - 16'h0001));
         end
      end
   end

endmodule

// ### logic/pss_selector.v
// Prioritized three-input supply selector control, with Wishbone registers.
// Assumes comparator flags, gate-off sense and reverse permits are
// synchronous to CLK; gates drive external switch transistors.
//
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "pss_defines.vh"

// Behaviour
// - good indicator low after 256ms in window
// - overvoltage flag invalidates its channel
// - undervoltage flag invalidates its channel
// - first channel connects whenever validated
// - second connects only if first fails
// - third connects only if both fail
// - disable drops gates, timers keep running
// - enabled connects highest valid channel
// - shutdown drops gates, resets all timers
// - shutdown release resumes validation and connection
// - cascade high: none valid, gates off, enabled
// - cascade high whenever shutdown asserted
// - cascade low when valid, running, enabled
// - cascade low when enable deasserted, unless shutdown asserted
// - connect only after reverse permit shown
// - disconnect after 8us out of window
// - higher valid channel preempts lower one
// - break before make on gate-off latch
module pss_selector
#(
   parameter TICK_CYCLES = `PSS_TICK_CYCLES,
   parameter VALID_TICKS = `PSS_VALID_TICKS
)
(
   input wire CLK,
   input wire SYS_RST,
   input wire CE,
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [3:0] WB_ADR_I,
   input wire [3:0] WB_SEL_I,
   input wire [31:0] WB_DAT_I,
   output reg [31:0] WB_DAT_O,
   output reg WB_ACK_O,
   input wire CHANNEL1_OVER_FLAG,
   input wire CHANNEL2_OVER_FLAG,
   input wire CHANNEL3_OVER_FLAG,
   input wire CHANNEL1_UNDER_FLAG,
   input wire CHANNEL2_UNDER_FLAG,
   input wire CHANNEL3_UNDER_FLAG,
   input wire ENABLE,
   input wire SHUTDOWN_REQUEST_N,
   input wire [2:0] GATE_OFF_SENSE,
   input wire [2:0] REVERSE_PERMIT,
   output reg CHANNEL1_GATE_ON,
   output reg CHANNEL2_GATE_ON,
   output reg CHANNEL3_GATE_ON,
   output reg CHANNEL1_GOOD_N,
   output reg CHANNEL2_GOOD_N,
   output reg CHANNEL3_GOOD_N,
   output reg CASCADE
);

   localparam ST_IDLE = 2'h0;
   localparam ST_MAKE = 2'h1;
   localparam ST_ON = 2'h2;
   localparam ST_BREAK = 2'h3;
   localparam FAULT_CYCLES = `PSS_FAULT_CYCLES;

   reg [31:0] tick_cnt;
   reg tick;
   reg soft_en;
   reg soft_sd;
   reg [1:0] event_bits;
   reg [1:0] state;
   reg [1:0] next_state;
   reg [2:0] cur;
   reg [2:0] next_cur;
   reg [2:0] gate;
   reg [2:0] next_gate;
   reg [2:0] off_latch;
   reg [2:0] want;
   reg ev_switch;
   reg ev_loss;
   reg next_cas;
   wire [2:0] fault;
   wire [2:0] valid;
   wire [2:0] flong;
   wire shutdown;
   wire enabled;
   wire run;
   wire wb_req;
   wire [1:0] idx;
   wire higher;
   wire cur_flong;

   // ****************************************
   // shared timebase
   // ****************************************

   // one tick pulse per timebase period
   always @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         tick_cnt <= 32'h00000000;
         tick <= 1'b0;
      end
      else if (CE)
      begin
         if (tick_cnt == (TICK_CYCLES - 1))
         begin
            tick_cnt <= 32'h00000000;
            tick <= 1'b1;
         end
         else
         begin
            tick_cnt <= tick_cnt + 32'h00000001;
            tick <= 1'b0;
         end
      end
   end

   // ****************************************
   // window qualification per channel
   // ****************************************

   assign fault = {CHANNEL3_OVER_FLAG | CHANNEL3_UNDER_FLAG,
                   CHANNEL2_OVER_FLAG | CHANNEL2_UNDER_FLAG,
                   CHANNEL1_OVER_FLAG | CHANNEL1_UNDER_FLAG};
   assign shutdown = !SHUTDOWN_REQUEST_N || soft_sd;
   assign enabled = ENABLE && soft_en;
   assign run = enabled && !shutdown;

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1)
      begin : chan
         pss_vtimer
         #(
            .VALID_TICKS(VALID_TICKS),
            .FAULT_CYCLES(FAULT_CYCLES)
         )
         u_timer
         (
            .clk(CLK),
            .rst(SYS_RST),
            .ce(CE),
            .tick(tick),
            .clr(shutdown),
            .fault(fault[g]),
            .valid(valid[g]),
            .fault_long(flong[g])
         );
      end
   endgenerate

   always @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         CHANNEL1_GOOD_N <= 1'b1;
         CHANNEL2_GOOD_N <= 1'b1;
         CHANNEL3_GOOD_N <= 1'b1;
      end
      else if (CE)
      begin
         CHANNEL1_GOOD_N <= !valid[0];
         CHANNEL2_GOOD_N <= !valid[1];
         CHANNEL3_GOOD_N <= !valid[2];
      end
   end

   // ****************************************
   // priority choice
   // ****************************************

   // highest-priority valid channel, one-hot
   always @*
   begin
      want = 3'h0;
      if (run)
      begin
         if (valid[0])
            want = 3'h1;
         else if (valid[1])
            want = 3'h2;
         else if (valid[2])
            want = 3'h4;
      end
   end

   assign higher = ((want & (cur - 3'h1)) != 3'h0);
   assign cur_flong = ((cur & flong) != 3'h0);

   // gate-off indications latched per channel
   always @(posedge CLK)
   begin
      if (SYS_RST)
         off_latch <= 3'h0;
      else if (CE)
         off_latch <= (off_latch | (GATE_OFF_SENSE & ~gate)) & ~next_gate;
   end

   // ****************************************
   // gate sequencer
   // ****************************************

   // next state of the break-before-make sequence
   always @*
   begin
      next_state = state;
      next_cur = cur;
      next_gate = gate;
      ev_switch = 1'b0;
      ev_loss = 1'b0;
      case (state)
         ST_IDLE:
         begin
            next_gate = 3'h0;
            if ((want != 3'h0) && (off_latch == 3'h7))
            begin
               next_cur = want;
               next_state = ST_MAKE;
            end
         end
         ST_MAKE:
         begin
            if (want != cur)
               next_state = ST_IDLE;
            else if ((cur & REVERSE_PERMIT) != 3'h0)
            begin
               next_gate = cur;
               next_state = ST_ON;
               ev_switch = 1'b1;
            end
         end
         ST_ON:
         begin
            if (!run || cur_flong || higher)
            begin
               next_gate = 3'h0;
               next_state = ST_BREAK;
               ev_loss = cur_flong;
            end
         end
         ST_BREAK:
         begin
            next_gate = 3'h0;
            if ((cur & off_latch) != 3'h0)
               next_state = ST_IDLE;
         end
         default:
         begin
            next_gate = 3'h0;
            next_state = ST_IDLE;
         end
      endcase
   end

   // sequencer registers and gate outputs
   always @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         state <= ST_IDLE;
         cur <= 3'h0;
         gate <= 3'h0;
         CHANNEL1_GATE_ON <= 1'b0;
         CHANNEL2_GATE_ON <= 1'b0;
         CHANNEL3_GATE_ON <= 1'b0;
      end
      else if (CE)
      begin
         state <= next_state;
         cur <= next_cur;
         gate <= next_gate;
         CHANNEL1_GATE_ON <= next_gate[0];
         CHANNEL2_GATE_ON <= next_gate[1];
         CHANNEL3_GATE_ON <= next_gate[2];
      end
   end

   // ****************************************
   // cascade output
   // ****************************************

   // cascade level from shutdown, enable and validity
   always @*
   begin
      next_cas = CASCADE;
      if (shutdown)
         next_cas = 1'b1;
      else if (!enabled)
         next_cas = 1'b0;
      else if (valid != 3'h0)
         next_cas = 1'b0;
      else if ((off_latch == 3'h7) && (gate == 3'h0))
         next_cas = 1'b1;
   end

   always @(posedge CLK)
   begin
      if (SYS_RST)
         CASCADE <= 1'b0;
      else if (CE)
         CASCADE <= next_cas;
   end

   // ****************************************
   // wishbone register slave
   // ****************************************

   assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   assign idx = WB_ADR_I[3:2];

   // ack, read data and register writes
   always @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h00000000;
         soft_en <= `PSS_CTRL_EN_RST;
         soft_sd <= `PSS_CTRL_SD_RST;
         event_bits <= 2'h0;
      end
      else if (CE)
      begin
         WB_ACK_O <= wb_req;
         WB_DAT_O <= 32'h00000000;
         // events set, write-one clears, set wins
         event_bits[`PSS_EV_SWITCH_BIT] <= ev_switch || (event_bits[`PSS_EV_SWITCH_BIT]
            && !(wb_req && WB_WE_I && WB_SEL_I[0] && (idx == `PSS_IDX_EVENT)
            && WB_DAT_I[`PSS_EV_SWITCH_BIT]));
         event_bits[`PSS_EV_LOSS_BIT] <= ev_loss || (event_bits[`PSS_EV_LOSS_BIT]
            && !(wb_req && WB_WE_I && WB_SEL_I[0] && (idx == `PSS_IDX_EVENT)
            && WB_DAT_I[`PSS_EV_LOSS_BIT]));
         if (wb_req && WB_WE_I && WB_SEL_I[0] && (idx == `PSS_IDX_CTRL))
         begin
            soft_en <= WB_DAT_I[`PSS_CTRL_EN_BIT];
            soft_sd <= WB_DAT_I[`PSS_CTRL_SD_BIT];
         end
         if (wb_req && !WB_WE_I)
         begin
            case (idx)
               `PSS_IDX_CTRL:
               begin
                  WB_DAT_O[`PSS_CTRL_EN_BIT] <= soft_en;
                  WB_DAT_O[`PSS_CTRL_SD_BIT] <= soft_sd;
               end
               `PSS_IDX_STATUS:
               begin
                  WB_DAT_O[`PSS_ST_GOOD_LSB + 2:`PSS_ST_GOOD_LSB] <= valid;
                  WB_DAT_O[`PSS_ST_GATE_LSB + 2:`PSS_ST_GATE_LSB] <= gate;
                  WB_DAT_O[`PSS_ST_CAS_BIT] <= CASCADE;
                  WB_DAT_O[`PSS_ST_OFF_LSB + 2:`PSS_ST_OFF_LSB] <= off_latch;
                  WB_DAT_O[`PSS_ST_FSM_LSB + 1:`PSS_ST_FSM_LSB] <= state;
               end
               `PSS_IDX_EVENT:
                  WB_DAT_O[`PSS_EV_LOSS_BIT:`PSS_EV_SWITCH_BIT] <= event_bits;
               default:
                  WB_DAT_O <= 32'h00000000;
            endcase
         end
      end
   end

endmodule

// ### testbench/pss_monitor.sv
// Checker for the supply selector pins.
// Assumes CE held high and the soft enable left at its reset value.
`timescale 1ns/100ps
module pss_monitor
(
   input wire CLK,
   input wire SYS_RST,
   input wire CHANNEL1_OVER_FLAG,
   input wire CHANNEL2_OVER_FLAG,
   input wire CHANNEL3_OVER_FLAG,
   input wire CHANNEL1_UNDER_FLAG,
   input wire CHANNEL2_UNDER_FLAG,
   input wire CHANNEL3_UNDER_FLAG,
   input wire ENABLE,
   input wire SHUTDOWN_REQUEST_N,
   input wire [2:0] GATE_OFF_SENSE,
   input wire [2:0] REVERSE_PERMIT,
   input wire CHANNEL1_GATE_ON,
   input wire CHANNEL2_GATE_ON,
   input wire CHANNEL3_GATE_ON,
   input wire CHANNEL1_GOOD_N,
   input wire CHANNEL2_GOOD_N,
   input wire CHANNEL3_GOOD_N,
   input wire CASCADE
);
   // gathered pin vectors
   wire [2:0] g = {CHANNEL3_GATE_ON, CHANNEL2_GATE_ON, CHANNEL1_GATE_ON};
   wire [2:0] gn = {CHANNEL3_GOOD_N, CHANNEL2_GOOD_N, CHANNEL1_GOOD_N};
   wire [2:0] flt = {CHANNEL3_OVER_FLAG | CHANNEL3_UNDER_FLAG,
      CHANNEL2_OVER_FLAG | CHANNEL2_UNDER_FLAG, CHANNEL1_OVER_FLAG | CHANNEL1_UNDER_FLAG};
   wire run = ENABLE && SHUTDOWN_REQUEST_N;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SYS_RST);
   // all inputs bad, gates confirmed off
   sequence s_idle;
      (run && flt == 3'h7 && g == 3'h0 && GATE_OFF_SENSE == 3'h7) [*3];
   endsequence
   a_one_gate: assert property ($onehot0(g))
      else $error("two gates on");
   a_reset_off: assert property (disable iff (1'b0) SYS_RST |=> g == 3'h0)
      else $error("gate on after reset");
   a_enable_drop: assert property (!ENABLE |=> g == 3'h0)
      else $error("gate on while disabled");
   a_shutdown_request_n_drop: assert property (!SHUTDOWN_REQUEST_N |=> g == 3'h0 && CASCADE)
      else $error("shutdown not honoured");
   a_cas_dis: assert property (!ENABLE && SHUTDOWN_REQUEST_N |=> !CASCADE)
      else $error("cascade high while disabled");
   a_cas_valid: assert property (run && gn != 3'h7 |=> !CASCADE)
      else $error("cascade high with a good input");
   a_cas_idle: assert property (s_idle |=> CASCADE)
      else $error("cascade low when idle");
   a_good_fault: assert property (flt != 3'h0 |-> ##2 (gn & $past(flt, 2)) == $past(flt, 2))
      else $error("good held through fault");
   a_permit_first: assert property ((g & ~$past(g) & ~$past(REVERSE_PERMIT)) == 3'h0)
      else $error("gate on without permit");
   a_break_make: assert property ((g & ~$past(g)) != 3'h0 |-> $past(g) == 3'h0)
      else $error("make before break");
endmodule
bind pss_selector pss_monitor i_mon (.CLK, .SYS_RST, .CHANNEL1_OVER_FLAG, .CHANNEL2_OVER_FLAG,
   .CHANNEL3_OVER_FLAG, .CHANNEL1_UNDER_FLAG, .CHANNEL2_UNDER_FLAG, .CHANNEL3_UNDER_FLAG,
   .ENABLE, .SHUTDOWN_REQUEST_N, .GATE_OFF_SENSE, .REVERSE_PERMIT, .CHANNEL1_GATE_ON,
   .CHANNEL2_GATE_ON, .CHANNEL3_GATE_ON, .CHANNEL1_GOOD_N, .CHANNEL2_GOOD_N,
   .CHANNEL3_GOOD_N, .CASCADE);

// ### testbench/pss_switch_model.sv
// Switch transistors and output sense for the selector.
// Assumes gate enables are levels on clk; slow stretches both answers.
`timescale 1ns/100ps
module pss_switch_model
(
   input wire clk,
   input wire slow,
   input wire [2:0] gate,
   output wire [2:0] off_sense,
   output wire [2:0] permit
);
   reg [2:0] h1 = 3'h0;
   reg [2:0] h2 = 3'h0;
   reg [3:0] droop = 4'h0;
   // gate discharge and output droop
   always @(posedge clk)
   begin
      h1 <= gate;
      h2 <= h1;
      droop <= (gate != 3'h0) ? 4'h0 : droop + {3'h0, droop != 4'hF};
   end
   assign off_sense = ~(h1 | (slow ? h2 : 3'h0));
   assign permit = {3{droop >= (slow ? 4'h8 : 4'h1)}};
endmodule

// ### testbench/tb.sv
// Self-checking bench for the supply selector.
// Assumes the switch model answers on the sense and permit pins.
`timescale 1ns/100ps
module tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, en = 1'b1, sdn = 1'b1, slow = 1'b0;
   logic [3:0] adr = 4'h0, sel = 4'h0;
   logic [31:0] dat = 32'h0, q;
   logic [2:0] ov = 3'h7, uv = 3'h0;
   wire [31:0] rdat;
   wire ack, cas, g1, g2, g3, n1, n2, n3;
   wire [2:0] sense, perm;
   wire [2:0] g = {g3, g2, g1};
   wire [2:0] gn = {n3, n2, n1};
   int bad_count = 0, samples_checked = 0, cyc_n = 0;
   always #5 clk = ~clk;
   pss_selector #(.TICK_CYCLES(4), .VALID_TICKS(4)) i_dut (.CLK(clk), .SYS_RST(rst),
      .CE(1'b1), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .CHANNEL1_OVER_FLAG(ov[0]), .CHANNEL2_OVER_FLAG(ov[1]), .CHANNEL3_OVER_FLAG(ov[2]),
      .CHANNEL1_UNDER_FLAG(uv[0]), .CHANNEL2_UNDER_FLAG(uv[1]), .CHANNEL3_UNDER_FLAG(uv[2]),
      .ENABLE(en), .SHUTDOWN_REQUEST_N(sdn), .GATE_OFF_SENSE(sense), .REVERSE_PERMIT(perm),
      .CHANNEL1_GATE_ON(g1), .CHANNEL2_GATE_ON(g2), .CHANNEL3_GATE_ON(g3),
      .CHANNEL1_GOOD_N(n1), .CHANNEL2_GOOD_N(n2), .CHANNEL3_GOOD_N(n3), .CASCADE(cas));
   pss_switch_model i_sw (.clk(clk), .slow(slow), .gate(g), .off_sense(sense), .permit(perm));
   task wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // one classic cycle, held until ack
   task wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= s;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task cy(input int n);
      repeat (n) @(posedge clk);
   endtask
   task wg(input logic [2:0] e, input int n);
      repeat (n)
      begin
         @(posedge clk);
         if (g === e) break;
      end
   endtask
   task t_regs;
      chk(g, 3'h0);
      wb(1'b1, 4'h0, 32'h2, 4'h0);
      wb(1'b1, 4'hC, 32'h2, 4'hF);
      wb(1'b0, 4'h0, 32'h0, 4'hF);
      chk(q, 32'h1);
      wb(1'b0, 4'hC, 32'h0, 4'hF);
      chk(q, 32'h0);
      wb(1'b0, 4'h4, 32'h0, 4'hF);
      chk(q & 32'h40, 32'h40);
   endtask
   task t_prio;
      @(posedge clk);
      ov <= 3'h3;
      cy(10);
      chk(gn, 3'h7);
      wg(3'h4, 200);
      chk(g, 3'h4);
      chk(gn, 3'h3);
      @(posedge clk);
      ov <= 3'h1;
      wg(3'h2, 200);
      chk(g, 3'h2);
      @(posedge clk);
      ov <= 3'h0;
      wg(3'h1, 200);
      chk(g, 3'h1);
      chk(cas, 1'b0);
   endtask
   task t_fault;
      @(posedge clk);
      uv <= 3'h1;
      cy(780);
      chk(g, 3'h1);
      chk(gn, 3'h1);
      wg(3'h2, 100);
      chk(g, 3'h2);
      @(posedge clk);
      uv <= 3'h0;
      cy(12);
      uv <= 3'h1;
      @(posedge clk);
      uv <= 3'h0;
      cy(10);
      chk(g, 3'h2);
      chk(gn, 3'h1);
      wg(3'h1, 200);
      chk(g, 3'h1);
   endtask
   task t_dis;
      @(posedge clk);
      en <= 1'b0;
      cy(3);
      chk(g, 3'h0);
      chk(cas, 1'b0);
      cy(40);
      chk(gn, 3'h0);
      @(posedge clk);
      en <= 1'b1;
      wg(3'h1, 50);
      chk(g, 3'h1);
   endtask
   task t_shutdown_request_n;
      @(posedge clk);
      sdn <= 1'b0;
      slow <= 1'b1;
      cy(3);
      chk(g, 3'h0);
      chk(cas, 1'b1);
      chk(gn, 3'h7);
      @(posedge clk);
      sdn <= 1'b1;
      cy(8);
      chk(gn, 3'h7);
      wg(3'h1, 200);
      chk(g, 3'h1);
   endtask
   task t_idle;
      @(posedge clk);
      ov <= 3'h7;
      wg(3'h0, 1000);
      cy(6);
      chk(cas, 1'b1);
      // cascade now enables a lower-priority selector
      chk(cas & en, 1'b1);
   endtask
   // event flags: set by connect and loss, write one clears
   task t_events;
      wb(1'b0, 4'h8, 32'h0, 4'hF);
      chk(q, 32'h3);
      wb(1'b1, 4'h8, 32'h1, 4'h1);
      wb(1'b0, 4'h8, 32'h0, 4'hF);
      chk(q, 32'h2);
      wb(1'b1, 4'h8, 32'h2, 4'h1);
      wb(1'b0, 4'h8, 32'h0, 4'hF);
      chk(q, 32'h0);
   endtask
   // slow droop: connection waits for the permit
   task t_permit;
      @(posedge clk);
      en <= 1'b0;
      @(posedge clk);
      en <= 1'b1;
      cy(7);
      chk(g, 3'h0);
      wg(3'h1, 50);
      chk(g, 3'h1);
   endtask
   // reset in mid-run with a gate on
   task t_rst;
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(g, 3'h0);
      chk(gn, 3'h7);
      wg(3'h1, 200);
      chk(g, 3'h1);
   endtask
   // hang guard
   always @(posedge clk)
   begin
      cyc_n++;
      if (cyc_n == 20000)
      begin
         bad_count++;
         wrap_up;
      end
   end
   initial
   begin
      cy(12);
      rst <= 1'b0;
      t_regs;
      t_prio;
      t_fault;
      t_events;
      t_dis;
      t_shutdown_request_n;
      t_permit;
      t_rst;
      t_idle;
      wrap_up;
   end
endmodule
